// *** asrc_ctrl.sv ***
`timescale 1ns/1ps
// Operation
// R1: Device stores input bit only during overlap of select low and strobe low.
// R2: Device output is high impedance whenever the write strobe is low.
// R3: Select low with strobe high makes the device read the addressed bit.
// R4: Hold output gate high when output must float with select low, strobe high.
// R5: Keep write strobe high throughout every read cycle.
// R6: Address is valid no later than select falls in a read.
// R7: Select or strobe stays high while address changes during writes.
// R8: Never drive data pins against the device output, including release time.
// R9: Old output held 3 ns after address change; new data within access time.
// R10: After select falls, output active no sooner than 3 ns, data by access.
// R11: After output gate falls, data valid within 7 or 8 ns.
// R12: After select rises, output floats within 7 or 8 ns.
// R13: After output gate rises, output floats within 7 or 8 ns.
// R14: Address, select and strobe held 10 or 11 ns before write end.
// R15: Input data valid 7 or 8 ns before write end, held 0 ns after.
// R16: After strobe falls, device output floats within 7 or 8 ns.
// R17: After write end, device output stays off at least 3 ns.
// R18: Space cycles by cycle time; keep address stable briefly after write.
// R19: Select low, gate and strobe high: device output floats.
// R20: Each access picks one of 16M bits through 24 address lines.
module asrc_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // User request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [asrc_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_wdata,
  output logic req_ready,
  // User answer
  output logic rsp_valid,
  output logic rsp_rdata,
  // Memory pins
  output logic [asrc_pkg::ADDR_W-1:0] word_address,
  output logic sram_cs_n,
  output logic sram_we_n,
  output logic sram_oe_n,
  output logic sram_din,
  input wire logic sram_dout
);

  asrc_pkg::asrc_state_t state_ff;
  asrc_pkg::asrc_state_t nxt_state;
  logic [asrc_pkg::ADDR_W-1:0] addr_ff;
  logic wdata_ff;
  logic write_ff;
  logic cs_n_ff;
  logic we_n_ff;
  logic oe_n_ff;
  logic rsp_valid_ff;
  logic rdata_ff;
  logic dout_meta_ff;
  logic dout_sync_ff;
  logic tmr_load;
  logic [asrc_pkg::CNT_W-1:0] tmr_val;
  logic tmr_done;

  // ****************************************************************
  // Phase timer
  // ****************************************************************
  asrc_timer u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next state and phase timer loads
  always_comb begin
    nxt_state = state_ff;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (state_ff)
      asrc_pkg::ASRC_IDLE: begin
        if (req_valid) begin
          // Address settles one cycle before any strobe falls
          nxt_state = asrc_pkg::ASRC_RSET; // R6 R7
        end
      end
      asrc_pkg::ASRC_RSET: begin
        tmr_load = 1'b1;
        if (write_ff) begin
          nxt_state = asrc_pkg::ASRC_WPUL; // R7
          tmr_val = asrc_pkg::CNT_W'(asrc_pkg::WR_PULSE_CYC); // R14
        end else begin
          // Access plus two synchroniser stages before sampling
          nxt_state = asrc_pkg::ASRC_RACC; // R6
          tmr_val = asrc_pkg::CNT_W'(asrc_pkg::RD_ACC_CYC + 2);
        end
      end
      asrc_pkg::ASRC_RACC: begin
        if (tmr_done) begin
          nxt_state = asrc_pkg::ASRC_GAP;
          tmr_load = 1'b1;
          tmr_val = asrc_pkg::CNT_W'(asrc_pkg::RELEASE_CYC); // R12 R13
        end
      end
      asrc_pkg::ASRC_WPUL: begin
        if (tmr_done) begin
          nxt_state = asrc_pkg::ASRC_WREC;
          tmr_load = 1'b1;
          tmr_val = asrc_pkg::CNT_W'(asrc_pkg::RECOV_CYC); // R18
        end
      end
      asrc_pkg::ASRC_WREC: begin
        if (tmr_done) begin
          nxt_state = asrc_pkg::ASRC_IDLE;
        end
      end
      asrc_pkg::ASRC_GAP: begin
        if (tmr_done) begin
          nxt_state = asrc_pkg::ASRC_IDLE; // R18
        end
      end
      default: begin
        nxt_state = asrc_pkg::ASRC_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= asrc_pkg::ASRC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Request accepted only in idle
  assign req_ready = (state_ff == asrc_pkg::ASRC_IDLE);

  // ****************************************************************
  // Address and write data
  // ****************************************************************
  // Latched on acceptance, stable until the next request
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_ff <= '0;
      wdata_ff <= 1'b0;
      write_ff <= 1'b0;
    end else if (req_valid && req_ready) begin
      addr_ff <= req_addr; // R20 R7
      wdata_ff <= req_wdata; // R15
      write_ff <= req_write;
    end
  end

  // ****************************************************************
  // Strobes
  // ****************************************************************
  // Select low during access and write pulse only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_ff <= 1'b1;
    end else begin
      cs_n_ff <= !((nxt_state == asrc_pkg::ASRC_RACC) ||
                   (nxt_state == asrc_pkg::ASRC_WPUL)); // R3 R1
    end
  end

  // Write strobe low only for the write pulse
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      we_n_ff <= 1'b1;
    end else begin
      we_n_ff <= (nxt_state != asrc_pkg::ASRC_WPUL); // R5 R1 R14
    end
  end

  // Output gate low only while reading, high otherwise
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= (nxt_state != asrc_pkg::ASRC_RACC); // R4 R11 R19
    end
  end

  assign word_address = addr_ff;
  assign sram_cs_n = cs_n_ff;
  assign sram_we_n = we_n_ff;
  assign sram_oe_n = oe_n_ff;
  // Separate input pin, never driven against the output pin
  assign sram_din = wdata_ff; // R8 R16 R17 R2

  // ****************************************************************
  // Read data capture
  // ****************************************************************
  // Two-stage synchroniser for the data output pin
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dout_meta_ff <= 1'b0;
      dout_sync_ff <= 1'b0;
    end else begin
      dout_meta_ff <= sram_dout;
      dout_sync_ff <= dout_meta_ff;
    end
  end

  // Sample at end of access, answer for one cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_ff <= 1'b0;
      rdata_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= (state_ff == asrc_pkg::ASRC_RACC) && tmr_done;
      if ((state_ff == asrc_pkg::ASRC_RACC) && tmr_done) begin
        rdata_ff <= dout_sync_ff; // R9
      end
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rdata_ff;

endmodule

// *** asrc_pkg.sv ***
package asrc_pkg;

  // ****************************************************************
  // Clock and geometry
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int ADDR_W = 24;

  // ****************************************************************
  // Device timing figures, slow grade, in ns
  // ****************************************************************
  localparam int T_RC_NS = 17;
  localparam int T_AA_NS = 17;
  localparam int T_ACS_NS = 17;
  localparam int T_OE_NS = 8;
  localparam int T_CHZ_NS = 8;
  localparam int T_OHZ_NS = 8;
  localparam int T_WC_NS = 17;
  localparam int T_CW_NS = 11;
  localparam int T_AW_NS = 11;
  localparam int T_WP_NS = 11;
  localparam int T_DW_NS = 8;
  localparam int T_WR_NS = 1;

  // ****************************************************************
  // Cycle counts: least times round up, never below one
  // ****************************************************************
  localparam int RD_ACC_NS = (T_AA_NS > T_ACS_NS) ? T_AA_NS : T_ACS_NS;
  localparam int RD_ACC_CYC =
    (RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PULSE_NS = (T_WP_NS > T_CW_NS) ? T_WP_NS : T_CW_NS;
  localparam int WR_PULSE_CYC =
    (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_NS = (T_CHZ_NS > T_OHZ_NS) ? T_CHZ_NS : T_OHZ_NS;
  localparam int RELEASE_CYC =
    (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_CYC = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // ****************************************************************
  // Controller states
  // ****************************************************************
  typedef enum logic [5:0] {
    ASRC_IDLE  = 6'h01,
    ASRC_RSET  = 6'h02,
    ASRC_RACC  = 6'h04,
    ASRC_WPUL  = 6'h08,
    ASRC_WREC  = 6'h10,
    ASRC_GAP   = 6'h20
  } asrc_state_t;

endpackage

// *** asrc_timer.sv ***
`timescale 1ns/1ps
// Down counter for phase lengths
module asrc_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Control
  input wire logic load,
  input wire logic [asrc_pkg::CNT_W-1:0] load_val,
  // Status
  output logic done
);

  logic [asrc_pkg::CNT_W-1:0] cnt_ff;

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Load wins, else count down to zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // Expired when the count reaches one or less
  // Count alone decides, so a load taken on done forms no loop
  assign done = (cnt_ff <= {{(asrc_pkg::CNT_W-1){1'b0}}, 1'b1});

endmodule

// *** asrc_props_properties.sv ***
`timescale 1ns/1ps
// Pin order checks on the memory controller
module asrc_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // User side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [asrc_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_wdata,
  input wire logic req_ready,
  input wire logic rsp_valid,
  // Memory pins
  input wire logic [asrc_pkg::ADDR_W-1:0] word_address,
  input wire logic sram_cs_n,
  input wire logic sram_we_n,
  input wire logic sram_oe_n,
  input wire logic sram_din
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_addr_quiet: assert property ($changed(word_address) |->
    sram_cs_n && $past(sram_cs_n)) else $error("address moved");
  a_addr_taken: assert property (req_valid && req_ready |=>
    word_address == $past(req_addr)) else $error("address not taken");
  a_read_walk: assert property (req_valid && req_ready && !req_write
    |-> ##3 (!sram_cs_n && !sram_oe_n && sram_we_n)
    ##2 (rsp_valid && sram_cs_n)) else $error("read walk wrong");
  a_write_walk: assert property (req_valid && req_ready && req_write
    |-> ##2 (!sram_cs_n && !sram_we_n && sram_oe_n
    && sram_din == $past(req_wdata, 2)) ##1 (sram_cs_n && sram_we_n))
    else $error("write walk wrong");
  a_gate_strobe_excl: assert property (sram_oe_n || sram_we_n)
    else $error("gate and strobe both low");
  a_recov_addr: assert property ($rose(sram_we_n) |->
    $stable(word_address)) else $error("address moved at write end");
  a_strobe_width: assert property ($fell(sram_we_n) |=>
    $rose(sram_we_n)) else $error("strobe width wrong");
  a_one_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
endmodule

bind asrc_ctrl asrc_props u_props (.*);

// *** asrc_sram_model.sv ***
`timescale 1ns/1ps
// Behavioural one-bit-wide static memory
module asrc_sram_model (
  // Pins from the controller
  input wire logic [23:0] word_address,
  input wire logic sram_cs_n,
  input wire logic sram_we_n,
  input wire logic sram_oe_n,
  input wire logic sram_din,
  // Data out
  output logic sram_dout
);
  bit mem [bit [23:0]];
  logic junk = 1'b0;
  logic val = 1'b0;
  wire on;
  // Store while select and strobe overlap
  always @* if (!sram_cs_n && !sram_we_n) mem[word_address] = sram_din;
  // Drive only on a read with gate low
  assign #8 on = !sram_cs_n && sram_we_n && !sram_oe_n;
  // Data settles one access time after address or write end
  always @(word_address or sram_we_n)
    val <= #17 mem.exists(word_address) ? mem[word_address] : 1'b0;
  // Floating line seen as changing noise
  always #7 junk = ~junk;
  assign sram_dout = on ? val : junk;
endmodule

// *** async_sram_16m_by_1_port_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the memory controller
module async_sram_16m_by_1_port_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [23:0] req_addr = 24'h000000;
  logic req_wdata = 1'b0;
  logic req_ready, rsp_valid, rsp_rdata, sram_dout;
  logic sram_cs_n, sram_we_n, sram_oe_n, sram_din;
  logic [23:0] word_address;
  logic exp_q[$];
  bit ref_mem [bit [23:0]];
  int fails = 0;
  int checked = 0;
  int seed = 20261;
  // Clock
  always #25 core_clk = ~core_clk;
  asrc_ctrl u_dut (.*);
  asrc_sram_model u_mem (.*);
  // Compare and count
  task automatic chk(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Verdict
  task automatic finish_test();
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One request, held until taken, expectation noted
  task automatic op(input logic w, input logic [23:0] a, input logic d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge core_clk);
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 20) fails++;
    if (w) ref_mem[a] = d;
    else exp_q.push_back(ref_mem.exists(a) ? ref_mem[a] : 1'b0);
  endtask
  // Oldest note against each answer
  always @(posedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("rsp_valid", 1'b0, 1'b1);
      else chk("rsp_rdata", exp_q.pop_front(), rsp_rdata);
    end
  end
  // Reset, random traffic on boundary and small addresses
  initial begin
    int r;
    logic [23:0] a;
    repeat (3) @(posedge core_clk);
    chk("cs_n", 1'b1, sram_cs_n);
    chk("we_n", 1'b1, sram_we_n);
    chk("oe_n", 1'b1, sram_oe_n);
    chk("rsp_valid", 1'b0, rsp_valid);
    reset_n <= 1'b1;
    for (int k = 0; k < 80; k++) begin
      r = $random(seed);
      a = (k % 3 == 0) ? {24{r[4]}} : {20'h00000, r[3:0]};
      op(r[5] | (k < 2), a, r[6]);
    end
    req_valid <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk("queue_empty", 1'b1, exp_q.size() == 0);
    finish_test();
  end
  // Watchdog
  initial begin
    repeat (2000) @(posedge core_clk);
    fails++;
    finish_test();
  end
endmodule
